// File: src/fll_closed_loop_tuner.sv
// Closed-loop tuner of a digital frequency-locked loop with its register port
//
// Functional notes
// - Closed loop regulates output to multiplier times reference, fine tuned automatically.
// - Reference clock comes from generic clock channel zero.
// - Target below minimum frequency gives the minimum frequency.
// - Configure enable, reference, steps, multiplier first; writing mode one starts loop.
// - Coarse and fine values are read-only to software in closed loop.
// - Coarse search starts from the coarse value already held.
// - Bypass-coarse-lock set at start skips the coarse stage.
// - Coarse stage searches coarse value, then sets coarse lock flag.
// - Fine stage tunes fine value close to target, then sets fine lock flag.
// - Coarse or fine lock flag raises interrupt when its enable is set.
// - Ready flag shows the output clock is usable.
// - Measured ratio minus multiplier is stored in the ratio difference field.
// - With hold frequency clear, drift is tracked without losing locks.
// - Fine overflow or underflow in closed loop sets out-of-bounds flag.
// - Reference stopped or too slow sets the reference-stopped flag.
// - Stopped reference behaves as open loop; restart resumes closed loop.
// - Reference-stopped rising edge raises interrupt when enabled.
// - Chill cycles skip a measurement by default; disable bit turns them off.
// - Relaxed lock criteria by default; quick-lock-disable bit makes them strict.
// - After reset the loop is open with the reset coarse and fine values.
`timescale 1ns/10ps
`include "fll_defines.svh"

module fll_closed_loop_tuner #(
    parameter int unsigned REF_STOP_CYCLES = `FLL_REF_STOP_CYC
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    // Reference clock from generic clock channel zero
    input wire logic REF_CLK_GCLK0_IN,
    // Register port
    input wire fll_pkg::reg_req_s REG_REQ_IN,
    output logic [31:0] RDATA_OUT,
    // Oscillator settings and status
    output logic [`FLL_COARSE_W-1:0] COARSE_OUT,
    output logic [`FLL_FINE_W-1:0] FINE_OUT,
    output logic READY_OUT,
    output logic IRQ_OUT
);
    import fll_pkg::*;

    localparam logic [`FLL_CNT_W-1:0] REF_STOP_LAST = `FLL_CNT_W'(REF_STOP_CYCLES - 1);
    localparam logic [`FLL_FINE_W-1:0] COARSE_TOP = `FLL_FINE_W'((1 << `FLL_COARSE_W) - 1);
    localparam logic [`FLL_FINE_W-1:0] FINE_TOP = `FLL_FINE_W'((1 << `FLL_FINE_W) - 1);
    localparam logic [`FLL_FINE_W-1:0] STEP_ONE = `FLL_FINE_W'(1);
    localparam logic signed [18:0] DIFF_HI = 19'sh07FFF;
    localparam logic signed [18:0] DIFF_LO = 19'sh78000;

    fll_state_s r;
    fll_state_s nx;
    logic ref_edge;
    logic closed;
    logic measure;
    logic ctrl_wr;
    logic [`FLL_CNT_W-1:0] meas;
    logic signed [18:0] diff_full;
    logic [`FLL_DIFF_W-1:0] diff_sat;
    logic [`FLL_DIFF_W-1:0] absd;
    logic [`FLL_DIFF_W-1:0] tol;
    logic dn;
    logic flip;
    logic moved;
    logic [10:0] mv;
    logic [`FLL_FINE_W-1:0] cur_step;
    logic [`FLL_FLAG_N-1:0] evt;
    logic [5:0] ctrl_new;

    ////////////////////////////////////////////////////////////////////////////
    // Moves a value by a step, clamping at the range ends; bit 10 flags a clamp
    function automatic logic [10:0] step_value(input logic [9:0] v, input logic [9:0] s,
                                               input logic down, input logic [9:0] vmax);
        logic [10:0] sum;
        sum = {1'b0, v} + {1'b0, s};
        if (down)
        begin
            step_value = (v < s) ? 11'h400 : {1'b0, v - s};
        end
        else
        begin
            step_value = (sum > {1'b0, vmax}) ? {1'b1, vmax} : sum;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Decoded conditions of the current cycle
    assign ref_edge = r.ref_sync[1] & ~r.ref_sync[2];
    assign closed = r.enable & r.mode;
    assign measure = ref_edge & closed & r.armed & (r.st != ST_OPEN);
    assign ctrl_wr = REG_REQ_IN.wr && (REG_REQ_IN.addr == `FLL_OFS_CTRL);
    assign meas = r.per_cnt + 1'b1;
    assign diff_full = $signed({1'b0, meas}) - $signed({3'b000, r.mult_factor});
    assign diff_sat = (diff_full > DIFF_HI) ? DIFF_HI[15:0] :
                      (diff_full < DIFF_LO) ? DIFF_LO[15:0] : diff_full[15:0];
    assign dn = diff_full > 0;
    assign absd = diff_sat[15] ? 16'(-diff_sat) : diff_sat;
    assign tol = r.strict ? `FLL_STRICT_TOL : `FLL_RELAXED_TOL;
    assign flip = dn != r.last_dn;
    assign cur_step = (r.step == '0) ? STEP_ONE : r.step;
    assign ctrl_new = REG_REQ_IN.wdata[5:0];

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        nx = r;
        moved = 1'b0;
        mv = '0;
        evt = '0;
        nx.rdata = '0;
        nx.ref_sync = {r.ref_sync[1:0], REF_CLK_GCLK0_IN};
        // Register writes other than control
        if (REG_REQ_IN.wr)
        begin
            case (REG_REQ_IN.addr)
                `FLL_OFS_MULT:
                begin
                    nx.mult_factor = REG_REQ_IN.wdata[`FLL_MULT_LSB +: `FLL_MULT_W];
                    nx.fine_step_max = REG_REQ_IN.wdata[`FLL_FINE_STEP_LSB +: `FLL_FINE_W];
                    nx.coarse_step_max = REG_REQ_IN.wdata[`FLL_COARSE_STEP_LSB +: `FLL_COARSE_W];
                end
                `FLL_OFS_VAL:
                begin
                    if (!closed)
                    begin
                        nx.coarse = REG_REQ_IN.wdata[`FLL_COARSE_LSB +: `FLL_COARSE_W];
                        nx.fine = REG_REQ_IN.wdata[`FLL_FINE_LSB +: `FLL_FINE_W];
                    end
                end
                `FLL_OFS_STAT: nx.oob = r.oob & ~REG_REQ_IN.wdata[`FLL_ST_OOB];
                `FLL_OFS_IEN_SET: nx.inten = r.inten | REG_REQ_IN.wdata[`FLL_FLAG_N-1:0];
                `FLL_OFS_IEN_CLR: nx.inten = r.inten & ~REG_REQ_IN.wdata[`FLL_FLAG_N-1:0];
                `FLL_OFS_IFLAG: nx.intflag = r.intflag & ~REG_REQ_IN.wdata[`FLL_FLAG_N-1:0];
                default: ;
            endcase
        end
        // Register reads, data in the following cycle only
        if (REG_REQ_IN.rd)
        begin
            case (REG_REQ_IN.addr)
                `FLL_OFS_CTRL: nx.rdata = {26'h0000000, r.strict, r.chill_off, r.bypass, r.hold,
                                           r.mode, r.enable};
                `FLL_OFS_MULT: nx.rdata = {r.coarse_step_max, r.fine_step_max, r.mult_factor};
                `FLL_OFS_VAL: nx.rdata = {r.diff, r.coarse, r.fine};
                `FLL_OFS_STAT: nx.rdata = {27'h0000000, r.rcs, r.oob, r.lockf, r.lockc, r.rdy};
                `FLL_OFS_IEN_SET: nx.rdata = {27'h0000000, r.inten};
                `FLL_OFS_IEN_CLR: nx.rdata = {27'h0000000, r.inten};
                `FLL_OFS_IFLAG: nx.rdata = {27'h0000000, r.intflag};
                default: nx.rdata = '0;
            endcase
        end
        // Reference period counter and stop detection
        if (ref_edge)
        begin
            nx.per_cnt = '0;
            nx.rcs = 1'b0;
            nx.armed = closed;
        end
        else
        begin
            if (r.per_cnt != '1)
            begin
                nx.per_cnt = r.per_cnt + 1'b1;
            end
            if (closed && r.per_cnt >= REF_STOP_LAST)
            begin
                nx.rcs = 1'b1;
                nx.armed = 1'b0;
            end
        end
        // Measurement and frequency tuner
        if (measure)
        begin
            nx.diff = diff_sat;
            if (r.chill)
            begin
                nx.chill = 1'b0;
            end
            else
            begin
                nx.last_dn = dn;
                unique case (r.st)
                    ST_COARSE:
                    begin
                        if (diff_sat == '0 || (flip && cur_step == STEP_ONE))
                        begin
                            nx.lockc = 1'b1;
                            nx.st = ST_FINE;
                            nx.step = r.fine_step_max;
                        end
                        else
                        begin
                            // Clamp at zero holds the minimum frequency
                            mv = step_value({4'h0, r.coarse}, cur_step, dn, COARSE_TOP);
                            nx.coarse = mv[`FLL_COARSE_W-1:0];
                            moved = 1'b1;
                            if (flip && cur_step > STEP_ONE)
                            begin
                                nx.step = {1'b0, cur_step[9:1]};
                            end
                        end
                    end
                    ST_FINE:
                    begin
                        if (absd <= tol || (flip && cur_step == STEP_ONE))
                        begin
                            nx.lockf = 1'b1;
                            nx.st = ST_TRACK;
                        end
                        else
                        begin
                            mv = step_value(r.fine, cur_step, dn, FINE_TOP);
                            nx.fine = mv[`FLL_FINE_W-1:0];
                            nx.oob = nx.oob | mv[10];
                            moved = 1'b1;
                            if (flip && cur_step > STEP_ONE)
                            begin
                                nx.step = {1'b0, cur_step[9:1]};
                            end
                        end
                    end
                    ST_TRACK:
                    begin
                        if (!r.hold && diff_sat != '0)
                        begin
                            mv = step_value(r.fine, STEP_ONE, dn, FINE_TOP);
                            nx.fine = mv[`FLL_FINE_W-1:0];
                            nx.oob = nx.oob | mv[10];
                            moved = 1'b1;
                        end
                    end
                    ST_OPEN: ;
                endcase
                nx.chill = moved & ~r.chill_off;
            end
        end
        // Control writes start or stop the loop
        if (ctrl_wr)
        begin
            nx.enable = ctrl_new[`FLL_CTRL_EN];
            nx.mode = ctrl_new[`FLL_CTRL_MODE];
            nx.hold = ctrl_new[`FLL_CTRL_HOLD];
            nx.bypass = ctrl_new[`FLL_CTRL_BYP];
            nx.chill_off = ctrl_new[`FLL_CTRL_CHILL_OFF];
            nx.strict = ctrl_new[`FLL_CTRL_STRICT];
            if (!(nx.enable && nx.mode))
            begin
                nx.st = ST_OPEN;
                nx.lockc = 1'b0;
                nx.lockf = 1'b0;
                nx.rcs = 1'b0;
                nx.armed = 1'b0;
            end
            else if (!closed)
            begin
                // Search begins from the held coarse value
                nx.st = nx.bypass ? ST_FINE : ST_COARSE;
                nx.step = nx.bypass ? r.fine_step_max : {4'h0, r.coarse_step_max};
                nx.lockc = nx.bypass;
                nx.lockf = 1'b0;
                nx.armed = 1'b0;
                nx.chill = 1'b0;
                nx.rcs = 1'b0;
            end
        end
        // Status flags and interrupt, event set wins over clear
        nx.rdy = nx.enable;
        evt[`FLL_ST_RDY] = nx.rdy & ~r.rdy;
        evt[`FLL_ST_LOCKC] = nx.lockc & ~r.lockc;
        evt[`FLL_ST_LOCKF] = nx.lockf & ~r.lockf;
        evt[`FLL_ST_OOB] = nx.oob & ~r.oob;
        evt[`FLL_ST_RCS] = nx.rcs & ~r.rcs;
        nx.intflag = nx.intflag | evt;
        nx.irq = |(nx.intflag & nx.inten);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            r <= '0;
            r.coarse <= `FLL_COARSE_RST;
            r.fine <= `FLL_FINE_RST;
        end
        else
        begin
            r <= nx;
        end
    end

    // Outputs straight from the state register
    assign RDATA_OUT = r.rdata;
    assign COARSE_OUT = r.coarse;
    assign FINE_OUT = r.fine;
    assign READY_OUT = r.rdy;
    assign IRQ_OUT = r.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    chk_values_ro: assert property (
        (REG_REQ_IN.wr && REG_REQ_IN.addr == `FLL_OFS_VAL && closed && !measure && !ctrl_wr)
        |=> $stable(r.coarse) && $stable(r.fine))
        else $error("value field changed by software in closed loop");
    chk_open_exit: assert property (
        (ctrl_wr && !(ctrl_new[`FLL_CTRL_EN] && ctrl_new[`FLL_CTRL_MODE]))
        |=> r.st == ST_OPEN && !r.lockc && !r.lockf)
        else $error("loop not open after mode cleared");
    chk_start_bypass: assert property (
        (ctrl_wr && !closed && ctrl_new[`FLL_CTRL_EN] && ctrl_new[`FLL_CTRL_MODE]
         && ctrl_new[`FLL_CTRL_BYP]) |=> r.st == ST_FINE && r.lockc)
        else $error("bypass start did not skip coarse stage");
    chk_start_coarse: assert property (
        (ctrl_wr && !closed && ctrl_new[`FLL_CTRL_EN] && ctrl_new[`FLL_CTRL_MODE]
         && !ctrl_new[`FLL_CTRL_BYP]) |=> r.st == ST_COARSE && r.coarse == $past(r.coarse))
        else $error("coarse search did not start from held value");
    chk_ref_stop: assert property (
        (closed && !ref_edge && r.per_cnt == REF_STOP_LAST && !ctrl_wr) |=> r.rcs)
        else $error("stopped reference not flagged");
    chk_stop_frozen: assert property (
        (r.rcs && !REG_REQ_IN.wr) [*2] |-> $stable(r.fine) && $stable(r.coarse))
        else $error("tuner moved while reference stopped");
    chk_lock_order: assert property (r.lockf |-> r.lockc)
        else $error("fine lock without coarse lock");
    // Lock and stop interrupts, ratio difference, chill skip, hold and fine bound
    chk_irq_lock: assert property (
        ($rose(r.lockc) && r.inten[`FLL_ST_LOCKC]) |-> IRQ_OUT && r.intflag[`FLL_ST_LOCKC])
        else $error("coarse lock interrupt missing");
    chk_irq_fine: assert property (
        ($rose(r.lockf) && r.inten[`FLL_ST_LOCKF]) |-> IRQ_OUT && r.intflag[`FLL_ST_LOCKF])
        else $error("fine lock interrupt missing");
    chk_irq_stop: assert property ($rose(r.rcs) && r.inten[`FLL_ST_RCS] |-> IRQ_OUT)
        else $error("reference stop interrupt missing");
    chk_diff_store: assert property (measure |=> r.diff == $past(diff_sat))
        else $error("ratio difference not stored");
    chk_chill_skip: assert property (
        (measure && r.chill && !ctrl_wr) |=> !r.chill && $stable(r.fine) && $stable(r.coarse))
        else $error("chill measurement was used");
    chk_hold_freeze: assert property (
        (measure && r.st == ST_TRACK && r.hold && !r.chill) |=> $stable(r.fine) && r.lockf)
        else $error("fine value moved with hold set");
    chk_fine_bound: assert property (
        (measure && r.st == ST_TRACK && !r.chill && !r.hold && dn && r.fine == '0) |=> r.oob)
        else $error("fine underflow not flagged");
    // Minimum frequency, drift steps, lock window and ready
    chk_coarse_floor: assert property (
        (measure && r.st == ST_COARSE && !r.chill && dn && r.coarse == '0 && !REG_REQ_IN.wr)
        |=> r.coarse == '0 && $stable(r.oob))
        else $error("coarse left its minimum");
    chk_track_step: assert property (
        (measure && r.st == ST_TRACK && !r.chill && !r.hold && !dn && diff_sat != '0
         && r.fine != FINE_TOP && !ctrl_wr) |=> r.fine == $past(r.fine) + 1'b1 && r.lockf)
        else $error("drift tracking did not step fine up");
    chk_lock_window: assert property (
        (measure && r.st == ST_FINE && !r.chill && absd > tol && !flip && !ctrl_wr)
        |=> !r.lockf)
        else $error("fine lock taken outside its window");
    chk_ready_follow: assert property (
        (ctrl_wr && ctrl_new[`FLL_CTRL_EN]) |=> READY_OUT)
        else $error("ready flag did not follow enable");

    // Main scenarios reached
    cov_fine_lock: cover property ($rose(r.lockf));
    cov_ref_stop: cover property ($rose(r.rcs));
    cov_restart: cover property (r.rcs ##1 !r.rcs && closed);
    cov_oob: cover property ($rose(r.oob));
    cov_hold_track: cover property (r.hold && r.st == ST_TRACK);
endmodule

// File: src/fll_defines.svh
// Constants of the closed-loop frequency tuner: offsets, fields, resets, counts
`ifndef FLL_DEFINES_SVH
`define FLL_DEFINES_SVH
// Register offsets
`define FLL_OFS_CTRL 8'h00
`define FLL_OFS_MULT 8'h04
`define FLL_OFS_VAL 8'h08
`define FLL_OFS_STAT 8'h0C
`define FLL_OFS_IEN_SET 8'h10
`define FLL_OFS_IEN_CLR 8'h14
`define FLL_OFS_IFLAG 8'h18
// Widths
`define FLL_AW 8
`define FLL_COARSE_W 6
`define FLL_FINE_W 10
`define FLL_MULT_W 16
`define FLL_DIFF_W 16
`define FLL_CNT_W 18
`define FLL_FLAG_N 5
// Control bits
`define FLL_CTRL_EN 0
`define FLL_CTRL_MODE 1
`define FLL_CTRL_HOLD 2
`define FLL_CTRL_BYP 3
`define FLL_CTRL_CHILL_OFF 4
`define FLL_CTRL_STRICT 5
// Multiplier and value field positions
`define FLL_MULT_LSB 0
`define FLL_FINE_STEP_LSB 16
`define FLL_COARSE_STEP_LSB 26
`define FLL_FINE_LSB 0
`define FLL_COARSE_LSB 10
`define FLL_DIFF_LSB 16
// Status and flag bits
`define FLL_ST_RDY 0
`define FLL_ST_LOCKC 1
`define FLL_ST_LOCKF 2
`define FLL_ST_OOB 3
`define FLL_ST_RCS 4
// Reset values
`define FLL_COARSE_RST 6'h1F
`define FLL_FINE_RST 10'h200
// Counts and lock windows
`define FLL_REF_STOP_CYC 131072
`define FLL_RELAXED_TOL 16'h0004
`define FLL_STRICT_TOL 16'h0001
`endif

// File: src/fll_pkg.sv
// Types of the closed-loop frequency tuner
`include "fll_defines.svh"
package fll_pkg;
    typedef enum logic [1:0] {ST_OPEN, ST_COARSE, ST_FINE, ST_TRACK} tune_e;
    // Register port request
    typedef struct packed {
        logic [`FLL_AW-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
    // Whole state of the tuner
    typedef struct packed {
        tune_e st;
        logic [2:0] ref_sync;
        logic enable, mode, hold, bypass, chill_off, strict;
        logic [`FLL_MULT_W-1:0] mult_factor;
        logic [`FLL_FINE_W-1:0] fine_step_max;
        logic [`FLL_COARSE_W-1:0] coarse_step_max;
        logic [`FLL_COARSE_W-1:0] coarse;
        logic [`FLL_FINE_W-1:0] fine;
        logic [`FLL_DIFF_W-1:0] diff;
        logic lockc, lockf, rdy, oob, rcs;
        logic [`FLL_FLAG_N-1:0] inten;
        logic [`FLL_FLAG_N-1:0] intflag;
        logic irq;
        logic [`FLL_CNT_W-1:0] per_cnt;
        logic armed, chill, last_dn;
        logic [`FLL_FINE_W-1:0] step;
        logic [31:0] rdata;
    } fll_state_s;
endpackage

// File: verif/fll_ref_clk_model.sv
// Reference clock source model standing at generic clock channel zero
`timescale 1ns/10ps

module fll_ref_clk_model (
    // Clock
    input wire logic clk_in,
    // Control
    input wire logic run_in,
    input wire logic [7:0] half_in,
    // Reference output
    output logic ref_out
);
    logic [7:0] cnt;

    ////////////////////////////////////////////////////////////////////////////////
    // Steady square wave of 2 x half_in cycles, parked low while stopped
    always_ff @(posedge clk_in)
    begin
        if (!run_in)
        begin
            cnt <= 8'h00;
            ref_out <= 1'b0;
        end
        else if (cnt + 8'h01 >= half_in)
        begin
            cnt <= 8'h00;
            ref_out <= ~ref_out;
        end
        else
        begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

// File: verif/tb_top.sv
// Self-checking bench of the closed-loop frequency tuner
`timescale 1ns/10ps
`include "fll_defines.svh"

`define CHK(what, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
        end \
    end

module tb_top;
    import fll_pkg::*;

    localparam int STOP_CYC = 64;
    typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} row_s;

    logic clk, arst_n, ref_clk, run, ready, irq;
    logic [7:0] half;
    reg_req_s req;
    logic [31:0] rdata, s;
    logic [5:0] coarse;
    logic [9:0] fine;
    int n_errors, n_checks, cycles, c;
    int t[2];
    row_s rows[8] = '{
        '{`FLL_OFS_CTRL, 32'h00000030, `FLL_OFS_CTRL, 32'h00000030},
        '{`FLL_OFS_CTRL, 32'h00000000, `FLL_OFS_CTRL, 32'h00000000},
        '{`FLL_OFS_MULT, 32'h10400010, `FLL_OFS_MULT, 32'h10400010},
        '{`FLL_OFS_VAL, 32'hFFFF4100, `FLL_OFS_VAL, 32'h00004100},
        '{`FLL_OFS_IEN_SET, 32'h00000016, `FLL_OFS_IEN_SET, 32'h00000016},
        '{`FLL_OFS_IEN_CLR, 32'h00000016, `FLL_OFS_IEN_SET, 32'h00000000},
        '{8'h1C, 32'hFFFFFFFF, 8'h1C, 32'h00000000},
        '{`FLL_OFS_STAT, 32'h0000001F, `FLL_OFS_STAT, 32'h00000000}
    };

    ////////////////////////////////////////////////////////////////////////////////
    // Design, reference source and clock
    fll_closed_loop_tuner #(
        .REF_STOP_CYCLES(STOP_CYC)
    ) dut_u (
        .CLK_IN(clk),
        .ARST_N_IN(arst_n),
        .REF_CLK_GCLK0_IN(ref_clk),
        .REG_REQ_IN(req),
        .RDATA_OUT(rdata),
        .COARSE_OUT(coarse),
        .FINE_OUT(fine),
        .READY_OUT(ready),
        .IRQ_OUT(irq)
    );

    fll_ref_clk_model ref_u (
        .clk_in(clk),
        .run_in(run),
        .half_in(half),
        .ref_out(ref_clk)
    );

    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Register port tasks, status polling and closing report
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task poll(input int b, input logic v);
        c = 0;
        do
        begin
            rd(`FLL_OFS_STAT, s);
            c += 2;
        end
        while (s[b] !== v && c < 3000);
    endtask

    task end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        clk = 1'b0;
        arst_n = 1'b0;
        run = 1'b0;
        half = 8'h08;
        req = '0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        `CHK("coarse", `FLL_COARSE_RST, coarse)
        `CHK("fine", `FLL_FINE_RST, fine)
        `CHK("ready", 1'b0, ready)
        `CHK("irq", 1'b0, irq)
        // Register table rows
        foreach (rows[i])
        begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, s);
            `CHK("readback", rows[i].ex, s)
        end
        `CHK("open coarse", 6'h10, coarse)
        `CHK("open fine", 10'h100, fine)
        // Lock with output on target
        @(posedge clk);
        run <= 1'b1;
        wr(`FLL_OFS_IEN_SET, 32'h00000006);
        wr(`FLL_OFS_CTRL, 32'h00000001);
        #1;
        `CHK("ready", 1'b1, ready)
        wr(`FLL_OFS_CTRL, 32'h00000003);
        poll(`FLL_ST_LOCKF, 1'b1);
        `CHK("coarse lock", 1'b1, s[`FLL_ST_LOCKC])
        `CHK("fine lock", 1'b1, s[`FLL_ST_LOCKF])
        `CHK("start coarse", 6'h10, coarse)
        `CHK("lock irq", 1'b1, irq)
        rd(`FLL_OFS_VAL, s);
        `CHK("difference", 16'h0000, s[31:16])
        wr(`FLL_OFS_VAL, 32'h00000000);
        #1;
        `CHK("locked coarse", 6'h10, coarse)
        `CHK("locked fine", 10'h100, fine)
        wr(`FLL_OFS_IFLAG, 32'h00000006);
        rd(`FLL_OFS_IFLAG, s);
        `CHK("cleared irq", 1'b0, irq)
        rd(`FLL_OFS_STAT, s);
        `CHK("kept locks", 2'b11, s[2:1])
        // Reference stops, then restarts
        wr(`FLL_OFS_IEN_SET, 32'h00000010);
        @(posedge clk);
        run <= 1'b0;
        poll(`FLL_ST_RCS, 1'b1);
        `CHK("ref stopped", 1'b1, s[`FLL_ST_RCS])
        `CHK("stop delay", 1'b1, c >= 40 && c <= 100)
        `CHK("stop irq", 1'b1, irq)
        `CHK("frozen coarse", 6'h10, coarse)
        @(posedge clk);
        run <= 1'b1;
        poll(`FLL_ST_RCS, 1'b0);
        `CHK("ref resumed", 1'b0, s[`FLL_ST_RCS])
        // Output too fast: coarse runs down to its minimum
        half <= 8'h09;
        wr(`FLL_OFS_CTRL, 32'h00000000);
        wr(`FLL_OFS_CTRL, 32'h00000001);
        wr(`FLL_OFS_CTRL, 32'h00000003);
        for (c = 0; c < 3000 && coarse !== 6'h00; c++) @(posedge clk);
        `CHK("min coarse", 6'h00, coarse)
        rd(`FLL_OFS_STAT, s);
        `CHK("no oob", 1'b0, s[`FLL_ST_OOB])
        rd(`FLL_OFS_VAL, s);
        `CHK("difference", 16'h0002, s[31:16])
        // Output slow, coarse stage bypassed, relaxed lock
        half <= 8'h07;
        wr(`FLL_OFS_CTRL, 32'h00000000);
        wr(`FLL_OFS_CTRL, 32'h00000009);
        wr(`FLL_OFS_CTRL, 32'h0000000B);
        rd(`FLL_OFS_STAT, s);
        `CHK("bypass lock", 1'b1, s[`FLL_ST_LOCKC])
        poll(`FLL_ST_LOCKF, 1'b1);
        `CHK("relaxed lock", 1'b1, s[`FLL_ST_LOCKF])
        rd(`FLL_OFS_VAL, s);
        `CHK("negative diff", 16'hFFFE, s[31:16])
        // Drift tracking moves fine, hold frequency freezes it
        repeat (100) @(posedge clk);
        #1;
        `CHK("drift up", 1'b1, fine > 10'h100)
        wr(`FLL_OFS_CTRL, 32'h0000000F);
        #1;
        s = {22'h0, fine};
        repeat (100) @(posedge clk);
        #1;
        `CHK("held fine", s[9:0], fine)
        // Strict lock: fine runs into its limit, with and without chill cycles
        for (int k = 0; k < 2; k++)
        begin
            wr(`FLL_OFS_CTRL, 32'h00000000);
            wr(`FLL_OFS_STAT, 32'h00000008);
            wr(`FLL_OFS_VAL, 32'h00004200);
            wr(`FLL_OFS_CTRL, 32'h00000029 | (k << 4));
            wr(`FLL_OFS_CTRL, 32'h0000002B | (k << 4));
            poll(`FLL_ST_OOB, 1'b1);
            t[k] = c;
            `CHK("out of bounds", 1'b1, s[`FLL_ST_OOB])
            `CHK("strict lock", 1'b0, s[`FLL_ST_LOCKF])
            `CHK("fine limit", 10'h3FF, fine)
        end
        `CHK("chill slower", 1'b1, t[0] > t[1])
        // Fine runs under zero while tracking a fast output
        half <= 8'h09;
        wr(`FLL_OFS_CTRL, 32'h00000000);
        wr(`FLL_OFS_STAT, 32'h00000008);
        wr(`FLL_OFS_VAL, 32'h00004000);
        wr(`FLL_OFS_CTRL, 32'h00000009);
        wr(`FLL_OFS_CTRL, 32'h0000000B);
        poll(`FLL_ST_OOB, 1'b1);
        `CHK("underflow", 1'b1, s[`FLL_ST_OOB])
        `CHK("locks kept", 2'b11, s[2:1])
        `CHK("fine floor", 10'h000, fine)
        // Reset in mid-run
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("coarse", `FLL_COARSE_RST, coarse)
        `CHK("fine", `FLL_FINE_RST, fine)
        `CHK("ready", 1'b0, ready)
        arst_n <= 1'b1;
        rd(`FLL_OFS_STAT, s);
        `CHK("stat after reset", 32'h00000000, s)
        `CHK("irq after reset", 1'b0, irq)
        end_of_test();
    end
endmodule
